// ---- src/flash_host_ctrl.v ----
// Host controller that sequences commands, status and power-down on a byte-wide boot flash.
`timescale 1ns/1ps
// Notes on behaviour
// - Supply-low flag blocks program until clear
// - Repeat full sequence after an abort
// - Write read-array before reading array again
// - First access after wake waits wake delay
`include "flash_host_map.vh"
module flash_host_ctrl #(
  parameter WAKE_CYC   = `T_WAKE_CYC,
  parameter ACCESS_CYC = `T_ACCESS_CYC,
  parameter WE_CYC     = `T_WE_CYC
) (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        reset_i,
  // Avalon-MM slave.
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  // Flash pins.
  output reg  [16:0] flash_addr_o,
  input  wire [7:0]  flash_dq_i,
  output reg  [7:0]  flash_dq_o,
  output reg         flash_dq_oe_o,
  output reg         flash_ce_n_o,
  output reg         flash_oe_n_o,
  output reg         flash_we_n_o,
  output reg         powerdown_reset_pin_n_o
);
  // Sequencer states.
  localparam S_IDLE  = 3'd0;
  localparam S_WR    = 3'd1;
  localparam S_WGAP  = 3'd2;
  localparam S_RD    = 3'd3;
  localparam S_RGAP  = 3'd4;
  localparam S_POLL  = 3'd5;
  localparam S_WAKE  = 3'd6;
  localparam S_DONE  = 3'd7;
  reg [2:0]  state;
  reg [2:0]  op;
  reg [1:0]  step;
  reg [9:0]  cnt;
  reg [16:0] addr_reg;
  reg [7:0]  data_reg;
  reg [7:0]  dev_status;
  reg [7:0]  rd_data;
  reg        blocked;
  reg        aborted;
  reg        wake_pend;
  reg        ack;
  wire       busy = (state != S_IDLE);
  wire       bus_hit = avs_read_i | avs_write_i;
  // Register writes answer at once; reads take one cycle so the data comes from a flop.
  assign avs_waitrequest_o = avs_read_i & ~ack;
  always @(posedge clk_i) begin
    if (reset_i) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack <= avs_read_i & ~ack;
      case (avs_address_i)
        `REG_ADDR:   avs_readdata_o <= {15'h0000, addr_reg};
        `REG_DATA:   avs_readdata_o <= {24'h00_0000, data_reg};
        `REG_STATUS: avs_readdata_o <= {16'h0000, dev_status, 4'h0, aborted,
                                        ~powerdown_reset_pin_n_o, blocked, busy};
        `REG_RDDATA: avs_readdata_o <= {24'h00_0000, rd_data};
        default:     avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end
  // Main sequencer: one order in flight, new orders while busy are dropped except power-down.
  always @(posedge clk_i) begin
    if (reset_i) begin
      state                   <= S_IDLE;
      op                      <= `OP_NONE;
      step                    <= 2'd0;
      cnt                     <= 10'd0;
      addr_reg                <= 17'h0_0000;
      data_reg                <= 8'h00;
      dev_status              <= `DEV_STATUS_RST;
      rd_data                 <= 8'h00;
      blocked                 <= 1'b0;
      aborted                 <= 1'b0;
      wake_pend               <= 1'b0;
      flash_addr_o            <= 17'h0_0000;
      flash_dq_o              <= 8'h00;
      flash_dq_oe_o           <= 1'b0;
      flash_ce_n_o            <= 1'b1;
      flash_oe_n_o            <= 1'b1;
      flash_we_n_o            <= 1'b1;
      powerdown_reset_pin_n_o <= 1'b0;
    end else begin
      // Address and data capture and power-down are handled outside the sequencer case.
      if (avs_write_i && avs_address_i == `REG_ADDR && !busy)
        addr_reg <= avs_writedata_i[16:0];
      if (avs_write_i && avs_address_i == `REG_DATA && !busy)
        data_reg <= avs_writedata_i[7:0];
      if (avs_write_i && avs_address_i == `REG_CTRL &&
          avs_writedata_i[`CTRL_OP_MSB:`CTRL_OP_LSB] == `OP_POWERDOWN) begin
        // Pulling the pin low aborts any running operation; status resets to 80H.
        powerdown_reset_pin_n_o <= 1'b0;
        if (state == S_POLL)
          aborted <= 1'b1;
        dev_status    <= `DEV_STATUS_RST;
        state         <= S_IDLE;
        flash_ce_n_o  <= 1'b1;
        flash_oe_n_o  <= 1'b1;
        flash_we_n_o  <= 1'b1;
        flash_dq_oe_o <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            if (avs_write_i && avs_address_i == `REG_CTRL) begin
              op   <= avs_writedata_i[`CTRL_OP_MSB:`CTRL_OP_LSB];
              step <= 2'd0;
              case (avs_writedata_i[`CTRL_OP_MSB:`CTRL_OP_LSB])
                `OP_WAKE: begin
                  // Wake delay is counted before the first access is allowed.
                  powerdown_reset_pin_n_o <= 1'b1;
                  wake_pend               <= 1'b1;
                  cnt                     <= 10'd0;
                  state                   <= S_WAKE;
                end
                `OP_PROGRAM, `OP_ERASE: begin
                  // A pending supply-low block refuses new attempts until cleared.
                  if (blocked || !powerdown_reset_pin_n_o) begin
                    state <= S_IDLE;
                  end else begin
                    aborted <= 1'b0;
                    state   <= S_WR;
                    cnt     <= 10'd0;
                  end
                end
                `OP_READ, `OP_WRITE, `OP_CLEAR: begin
                  // Pin low disables the device, so nothing is driven then.
                  if (powerdown_reset_pin_n_o) begin
                    // A read first writes read-array, so a latch left in another mode cannot hide the array.
                    state <= S_WR;
                    cnt   <= 10'd0;
                  end
                end
                default: state <= S_IDLE;
              endcase
            end
          end
          S_WAKE: begin
            cnt <= cnt + 10'd1;
            if (cnt >= WAKE_CYC[9:0] - 10'd1) begin
              // After wake the latch holds read-array and status is 80H.
              wake_pend  <= 1'b0;
              dev_status <= `DEV_STATUS_RST;
              state      <= S_IDLE;
            end
          end
          S_WR: begin
            // Both select and write strobe go low together for a command write.
            flash_ce_n_o  <= 1'b0;
            flash_we_n_o  <= 1'b0;
            flash_dq_oe_o <= 1'b1;
            flash_addr_o  <= addr_reg;
            case (op)
              `OP_PROGRAM: flash_dq_o <= (step == 2'd0) ? `CMD_PROG_SETUP : data_reg;
              `OP_ERASE:   flash_dq_o <= (step == 2'd0) ? `CMD_ERASE_SETUP : `CMD_ERASE_CONF;
              `OP_CLEAR:   flash_dq_o <= (step == 2'd0) ? `CMD_CLEAR : `CMD_READ_ARRAY;
              `OP_READ:    flash_dq_o <= `CMD_READ_ARRAY;
              default:     flash_dq_o <= data_reg;
            endcase
            cnt <= cnt + 10'd1;
            if (cnt >= WE_CYC[9:0]) begin
              flash_we_n_o <= 1'b1;
              flash_ce_n_o <= 1'b1;
              cnt          <= 10'd0;
              state        <= S_WGAP;
            end
          end
          S_WGAP: begin
            flash_dq_oe_o <= 1'b0;
            step          <= step + 2'd1;
            cnt           <= 10'd0;
            case (op)
              // Setup then confirm is needed before the array can change.
              `OP_PROGRAM, `OP_ERASE: state <= (step == 2'd0) ? S_WR : S_POLL;
              // Clear zeroes the error flags, then read-array is restored.
              `OP_CLEAR: begin
                if (step == 2'd0) begin
                  dev_status[`SR_SUPPLY_LOW] <= 1'b0;
                  dev_status[`SR_PROG_ERR]   <= 1'b0;
                  dev_status[`SR_ERASE_ERR]  <= 1'b0;
                  blocked                    <= 1'b0;
                  state                      <= S_WR;
                end else begin
                  state <= S_DONE;
                end
              end
              // Array read always follows a read-array command write.
              `OP_READ: state <= S_RD;
              default:  state <= S_DONE;
            endcase
          end
          S_RD, S_POLL: begin
            // Read cycle; poll reads status after a program or erase.
            flash_ce_n_o <= 1'b0;
            flash_oe_n_o <= 1'b0;
            flash_addr_o <= addr_reg;
            cnt          <= cnt + 10'd1;
            if (cnt >= ACCESS_CYC[9:0]) begin
              flash_ce_n_o <= 1'b1;
              flash_oe_n_o <= 1'b1;
              cnt          <= 10'd0;
              if (state == S_RD) begin
                rd_data <= flash_dq_i;
                state   <= S_DONE;
              end else begin
                dev_status <= flash_dq_i;
                if (flash_dq_i[`SR_READY]) begin
                  // Supply-low blocks further attempts; errors just stand.
                  blocked <= flash_dq_i[`SR_SUPPLY_LOW];
                  // Leave the latch in read-array mode for the next read.
                  op    <= `OP_READ;
                  step  <= 2'd0;
                  state <= S_RGAP;
                end
              end
            end
          end
          S_RGAP: begin
            state <= S_WR;
            // An aborted job needs its full sequence repeated by software.
          end
          default: begin
            flash_dq_oe_o <= 1'b0;
            state         <= S_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ---- src/flash_host_map.vh ----
// Register offsets, field positions, reset values and timing counts of the flash host controller.
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH
// Controller registers on the Avalon-MM slave (word index = byte address / 4).
`define REG_CTRL        4'h0
`define REG_ADDR        4'h1
`define REG_DATA        4'h2
`define REG_STATUS      4'h3
`define REG_RDDATA      4'h4
`define ADDR_W          4
// Order codes written to the control register.
`define OP_NONE         3'h0
`define OP_READ         3'h1
`define OP_WRITE        3'h2
`define OP_PROGRAM      3'h3
`define OP_ERASE        3'h4
`define OP_CLEAR        3'h5
`define OP_POWERDOWN    3'h6
`define OP_WAKE         3'h7
// Control register fields.
`define CTRL_OP_LSB     0
`define CTRL_OP_MSB     2
// Host status register fields.
`define ST_BUSY         0
`define ST_BLOCKED      1
`define ST_PWRDN        2
`define ST_ABORTED      3
`define ST_DEV_LSB      8
`define ST_DEV_MSB      15
// Device command bytes and status bits.
`define CMD_READ_ARRAY  8'hFF
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR       8'h50
`define CMD_PROG_SETUP  8'h40
`define CMD_ERASE_SETUP 8'h20
`define CMD_ERASE_CONF  8'hD0
`define DEV_STATUS_RST  8'h80
`define SR_READY        7
`define SR_ERASE_ERR    5
`define SR_PROG_ERR     4
`define SR_SUPPLY_LOW   3
// Timing in ns and derived cycle counts at 200 MHz.
`define CLK_NS          5
`define T_ACCESS_NS     150
`define T_WAKE_NS       600
`define T_WE_NS         60
`define T_ACCESS_CYC    ((`T_ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WAKE_CYC      ((`T_WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WE_CYC        ((`T_WE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- sim/flash_host_ctrl_properties.sv ----
// Concurrent checks on the flash pins and bus handshake of the host controller.
`timescale 1ns/1ps
module flash_host_ctrl_properties #(
  parameter WAKE_CYC = 120
) (
  input wire        clk_i,
  input wire        reset_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire        avs_waitrequest_o,
  input wire [16:0] flash_addr_o,
  input wire [7:0]  flash_dq_o,
  input wire        flash_dq_oe_o,
  input wire        flash_ce_n_o,
  input wire        flash_oe_n_o,
  input wire        flash_we_n_o,
  input wire        powerdown_reset_pin_n_o
);
  reg [15:0] wcnt;
  // Cycles since the pin rose; it saturates so a long idle spell cannot wrap it.
  always @(posedge clk_i) begin
    if (reset_i || !powerdown_reset_pin_n_o) wcnt <= 16'h0000;
    else if (wcnt < WAKE_CYC) wcnt <= wcnt + 16'h0001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence setup_sent;
    $rose(flash_we_n_o) && ($past(flash_dq_o) == 8'h40 || $past(flash_dq_o) == 8'h20);
  endsequence
  chk_write_select: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o)
    else $error("write strobe without select");
  chk_pd_quiet: assert property (!powerdown_reset_pin_n_o && $past(!powerdown_reset_pin_n_o) |-> flash_we_n_o)
    else $error("strobe during power-down");
  chk_wake_delay: assert property (!flash_oe_n_o |-> wcnt >= WAKE_CYC)
    else $error("read before wake delay");
  chk_no_contention: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
    else $error("bus driven during read");
  chk_write_hold: assert property (!flash_we_n_o && $past(!flash_we_n_o) |-> $stable(flash_dq_o) && $stable(flash_addr_o))
    else $error("write data moved");
  chk_confirm_follows: assert property (setup_sent |-> ##[2:100] $fell(flash_we_n_o))
    else $error("setup without confirm");
  chk_read_answer: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("read answer late");
  chk_write_nowait: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
endmodule
bind flash_host_ctrl flash_host_ctrl_properties #(.WAKE_CYC(WAKE_CYC)) flash_host_ctrl_properties_i (.clk_i, .reset_i,
  .avs_read_i, .avs_write_i, .avs_waitrequest_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o, .flash_ce_n_o,
  .flash_oe_n_o, .flash_we_n_o, .powerdown_reset_pin_n_o);

// ---- sim/flash_device_model.sv ----
// Behavioural byte-wide flash: command latch, status byte and deep power-down.
`timescale 1ns/1ps
module flash_device_model #(
  parameter BUSY_CYC = 80,
  parameter WAKE_CYC = 100
) (
  input  wire        clk_i,
  input  wire        supply_low_i,
  input  wire [16:0] addr_i,
  input  wire [7:0]  dq_i,
  output wire [7:0]  dq_o,
  input  wire        ce_n_i,
  input  wire        oe_n_i,
  input  wire        we_n_i,
  input  wire        pd_n_i
);
  reg [7:0] cmd, status, pend, data, adr, busy, wake;
  reg [7:0] last = 8'h00;
  reg [7:0] mem [0:255];
  reg       wr_q;
  integer   i;
  wire      wr_now = pd_n_i && !ce_n_i && !we_n_i;
  // An idle bus shows a toggling pattern, so a host never reads a stale byte.
  assign dq_o = (pd_n_i && wake == 0 && !ce_n_i && !oe_n_i) ? (cmd == 8'hff ? mem[adr] : status) : ~last;
  // Commands land when strobe or select rises to end a write; the pin held low resets the latch to read-array.
  always @(posedge clk_i) begin
    wr_q <= wr_now;
    last <= dq_o;
    if (!ce_n_i) adr <= addr_i[7:0];
    if (wr_now) data <= dq_i;
    if (!pd_n_i) begin
      cmd <= 8'hff;
      status <= 8'h80;
      pend <= 8'h00;
      busy <= 8'h00;
      wake <= WAKE_CYC[7:0];
    end else begin
      if (wake != 0) wake <= wake - 8'h01;
      if (busy == 8'h01) status[7] <= 1'b1;
      if (busy != 0) busy <= busy - 8'h01;
      if (wr_q && !wr_now) begin
        cmd <= pend != 0 ? 8'h70 : data;
        pend <= (pend == 0 && (data == 8'h40 || data == 8'h20)) ? data : 8'h00;
        if (pend == 0 && data == 8'h50) status[5:3] <= 3'b000;
        if (pend != 0 && (status[3] || supply_low_i)) status <= status | (pend == 8'h40 ? 8'h18 : 8'h28);
        else if (pend == 8'h40 || (pend == 8'h20 && data == 8'hd0)) begin
          for (i = 0; i < 256; i = i + 1) if (pend == 8'h20 || i == adr) mem[i] <= pend == 8'h20 ? 8'hff : mem[i] & data;
          busy <= BUSY_CYC[7:0];
          status[7] <= 1'b0;
        end else if (pend == 8'h20) status[5:4] <= 2'b11;
      end
    end
  end
endmodule

// ---- sim/flash_host_ctrl_tb.sv ----
// Self-checking bench driving the flash host controller against a behavioural flash.
`timescale 1ns/1ps
`include "flash_host_map.vh"
module flash_host_ctrl_tb;
  reg         clk_i = 1'h0;
  reg         reset_i = 1'h1;
  reg         avs_read_i = 1'h0;
  reg         avs_write_i = 1'h0;
  reg         supply_low = 1'h0;
  reg  [3:0]  avs_address_i = 4'h0;
  reg  [31:0] avs_writedata_i = 32'h0000_0000;
  reg  [31:0] rd;
  wire [31:0] avs_readdata_o;
  wire [16:0] flash_addr_o;
  wire [7:0]  flash_dq_o, dev_dq;
  wire        avs_waitrequest_o, flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, powerdown_reset_pin_n_o;
  wire [7:0]  flash_dq_i = flash_dq_oe_o ? flash_dq_o : dev_dq;
  integer     failures = 0;
  integer     n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  flash_host_ctrl flash_host_ctrl_i (.clk_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_readdata_o, .avs_waitrequest_o, .flash_addr_o, .flash_dq_i, .flash_dq_o, .flash_dq_oe_o, .flash_ce_n_o,
    .flash_oe_n_o, .flash_we_n_o, .powerdown_reset_pin_n_o);
  flash_device_model flash_device_model_i (.clk_i, .supply_low_i(supply_low), .addr_i(flash_addr_o),
    .dq_i(flash_dq_i), .dq_o(dev_dq), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
    .pd_n_i(powerdown_reset_pin_n_o));
  // Bus tasks hold each request until waitrequest is seen low at an edge.
  task xfer(input w, input [3:0] a, input [31:0] d);
    begin
      avs_address_i <= a;
      avs_writedata_i <= d;
      if (w) avs_write_i <= 1'h1;
      else avs_read_i <= 1'h1;
      @(posedge clk_i);
      while (avs_waitrequest_o) @(posedge clk_i);
      rd = avs_readdata_o;
      avs_write_i <= 1'h0;
      avs_read_i <= 1'h0;
      @(posedge clk_i);
    end
  endtask
  task issue(input [2:0] o, input [16:0] a, input [7:0] d);
    begin
      xfer(1'h1, `REG_ADDR, {15'h0000, a});
      xfer(1'h1, `REG_DATA, {24'h00_0000, d});
      xfer(1'h1, `REG_CTRL, {29'h0000_0000, o});
    end
  endtask
  task poll;
    begin
      xfer(1'h0, `REG_STATUS, 32'h0000_0000);
      while (rd[`ST_BUSY] !== 1'h0) xfer(1'h0, `REG_STATUS, 32'h0000_0000);
    end
  endtask
  task op(input [2:0] o, input [16:0] a, input [7:0] d);
    begin
      issue(o, a, d);
      poll;
    end
  endtask
  task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rd_byte(input [16:0] a, input [7:0] e);
    begin
      op(`OP_READ, a, 8'h00);
      xfer(1'h0, `REG_RDDATA, 32'h0000_0000);
      chk("rddata", {24'h00_0000, e}, rd & 32'h0000_00ff);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // Watchdog: the whole sequence needs well under a tenth of this span.
  initial begin
    #400000;
    failures = failures + 1;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'h0;
    xfer(1'h0, 4'hf, 32'h0000_0000);
    poll;
    chk("status", 32'h0000_8004, rd & 32'h0000_ff0f);
    $display("test reset done");
    op(`OP_WAKE, 17'h0_0000, 8'h00);
    op(`OP_ERASE, 17'h0_0000, 8'h00);
    op(`OP_PROGRAM, 17'h0_0005, 8'ha5);
    chk("status", 32'h0000_8000, rd & 32'h0000_ff0f);
    op(`OP_WRITE, 17'h0_0005, 8'h3c);
    rd_byte(17'h0_0005, 8'ha5);
    $display("test program done");
    supply_low <= 1'h1;
    op(`OP_PROGRAM, 17'h0_0006, 8'h0f);
    chk("status", 32'h0000_9802, rd & 32'h0000_ff0f);
    supply_low <= 1'h0;
    op(`OP_PROGRAM, 17'h0_0006, 8'h0f);
    rd_byte(17'h0_0006, 8'hff);
    op(`OP_CLEAR, 17'h0_0000, 8'h00);
    chk("status", 32'h0000_8000, rd & 32'h0000_ff0f);
    op(`OP_PROGRAM, 17'h0_0006, 8'h0f);
    rd_byte(17'h0_0006, 8'h0f);
    $display("test supply low done");
    issue(`OP_PROGRAM, 17'h0_0007, 8'h12);
    repeat (60) @(posedge clk_i);
    xfer(1'h1, `REG_CTRL, {29'h0000_0000, `OP_POWERDOWN});
    poll;
    chk("status", 32'h0000_000c, rd & 32'h0000_000f);
    op(`OP_WAKE, 17'h0_0000, 8'h00);
    op(`OP_PROGRAM, 17'h0_0007, 8'h12);
    rd_byte(17'h0_0007, 8'h12);
    $display("test abort done");
    print_verdict;
  end
endmodule
